// ==== spi_stat_cs.sv ====
// Status flags, interrupt mask and per-chip-select timing of a master serial interface.
// Assumes an APB master on core_clk and DMA counters supplied by the DMA unit.
`timescale 1ns/1ps
`include "spi_stat_regs.svh"

module spi_stat_cs #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spi_stat_pkg::dma_counts_t dma_counts,
  input wire logic rx_dma_count_done,
  input wire logic tx_dma_count_done,
  input wire logic mode_fault_event,
  input wire logic slave_select_input,
  input wire logic miso,
  output logic serial_clock_pin,
  output logic mosi,
  output logic [3:0] peripheral_select_lines,
  output logic irq
);

  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("CNT_W must be 1 to 16");
  end

  spi_stat_pkg::cs_cfg_t csr_ff [4];
  spi_stat_pkg::eng_state_t st_ff;
  logic [9:0] mask_ff;
  logic en_ff, rx_word_ready_ff, mode_fault_flag_ff, ovr_ff, slave_select_rise_flag_ff, txe_ff, tx_dma_buffer_empty_ff, rx_dma_buffer_full_ff;
  logic ss_prev_ff;
  logic hold_full_ff, hold_last_ff, last_ff, cs_on_ff;
  logic [15:0] hold_data_ff, sh_ff, rsh_ff, rdr_ff;
  logic [1:0] hold_cs_ff, cur_ff;
  logic [13:0] cnt_ff;
  logic [4:0] edge_ff;
  logic pready_ff, pslverr_ff, irq_ff, sclk_ff, mosi_ff;
  logic [31:0] prdata_ff;
  logic [3:0] cs_lines_ff;

  logic acc, wr_done, rd_done, mapped;
  logic wr_ctrl, wr_txd, rd_stat, rd_rxd;
  logic [31:0] rd_val;
  logic [9:0] status10;
  spi_stat_pkg::cs_cfg_t cfg, ncfg;
  logic [4:0] wlen, last_edge;
  logic tick, word_end, go_on, release_cs, take;
  logic [15:0] aligned, rx_next;

  function automatic logic [4:0] word_len(input logic [3:0] code);
    // Reserved codes are clamped to the longest word rather than left undefined
    if (code > `WLEN_MAX_CODE) begin
      word_len = `WLEN_BASE + 5'(`WLEN_MAX_CODE);
    end else begin
      word_len = `WLEN_BASE + 5'(code);
    end
  endfunction

  // Idle-level half gets the odd cycle so one period is exactly the divisor; divisors 0 and 1 give two cycles
  function automatic logic [13:0] half_len(input logic [7:0] div, input logic odd);
    logic [7:0] h;
    h = odd ? (div >> 1) : 8'((9'(div) + 9'h001) >> 1);
    if (h == 8'h00) begin
      h = 8'h01;
    end
    half_len = {6'h00, h};
  endfunction

  // APB decode: answer comes one cycle into the access phase
  always_comb begin
    acc = psel && penable;
    wr_done = acc && pready_ff && pwrite;
    rd_done = acc && pready_ff && !pwrite;
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == `OFS_CTRL) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `OFS_RXDATA) begin
      rd_val = {16'h0000, rdr_ff};
    end else if (paddr == `OFS_TXDATA) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `OFS_STATUS) begin
      rd_val = {15'h0000, en_ff, 6'h00, status10};
    end else if (paddr == `OFS_IRQ_SET || paddr == `OFS_IRQ_CLR) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `OFS_IRQ_MASK) begin
      rd_val = {22'h000000, mask_ff};
    end else if (paddr >= `OFS_CSCFG0 && paddr <= `OFS_CSCFG3 && paddr[1:0] == 2'b00) begin
      rd_val = csr_ff[paddr[3:2]] & `CSCFG_RSV_MASK;
    end else begin
      mapped = 1'b0;
    end
    wr_ctrl = wr_done && paddr == `OFS_CTRL;
    wr_txd = wr_done && paddr == `OFS_TXDATA;
    rd_stat = rd_done && paddr == `OFS_STATUS;
    rd_rxd = rd_done && paddr == `OFS_RXDATA;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc && !pready_ff;
      pslverr_ff <= acc && !pready_ff && !mapped;
      // Data stands only beside pready, so writes and error answers carry zero
      prdata_ff <= (acc && !pready_ff && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        csr_ff[i] <= `CSCFG_RST;
      end
    end else if (wr_done && paddr >= `OFS_CSCFG0 && paddr <= `OFS_CSCFG3
                 && paddr[1:0] == 2'b00) begin
      csr_ff[paddr[3:2]] <= pwdata & `CSCFG_RSV_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_ff <= `MASK_RST;
    end else if (wr_done && paddr == `OFS_IRQ_SET) begin
      mask_ff <= mask_ff | pwdata[9:0];
    end else if (wr_done && paddr == `OFS_IRQ_CLR) begin
      mask_ff <= mask_ff & ~pwdata[9:0];
    end
  end

  // Disable wins when both command bits are written together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_ff <= 1'b0;
    end else if (wr_ctrl && pwdata[`CTRL_DIS_BIT]) begin
      en_ff <= 1'b0;
    end else if (wr_ctrl && pwdata[`CTRL_EN_BIT]) begin
      en_ff <= 1'b1;
    end
  end

  // Holding register for the next word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_full_ff <= 1'b0;
      hold_data_ff <= 16'h0000;
      hold_cs_ff <= 2'b00;
      hold_last_ff <= 1'b0;
    end else if (wr_txd) begin
      hold_full_ff <= 1'b1;
      hold_data_ff <= pwdata[15:0];
      hold_cs_ff <= pwdata[`TXD_CS_LSB +: 2];
      hold_last_ff <= pwdata[`TXD_LAST_BIT];
    end else if (take) begin
      hold_full_ff <= 1'b0;
    end
  end

  // Engine decode
  always_comb begin
    cfg = csr_ff[cur_ff];
    ncfg = csr_ff[hold_cs_ff];
    wlen = word_len(cfg.word_bits);
    last_edge = 5'((6'(wlen) << 1) - 6'h01);
    tick = cnt_ff <= 14'h0001;
    word_end = st_ff == spi_stat_pkg::ST_SHIFT && tick && edge_ff == last_edge;
    go_on = hold_full_ff && en_ff && hold_cs_ff == cur_ff && !last_ff;
    release_cs = last_ff || !cfg.chip_select_hold;
    aligned = hold_data_ff << (5'h10 - word_len(ncfg.word_bits));
    rx_next = {rsh_ff[14:0], miso};
    take = 1'b0;
    case (st_ff)
      spi_stat_pkg::ST_IDLE: take = hold_full_ff && en_ff && cs_on_ff
                                    && hold_cs_ff == cur_ff;
      spi_stat_pkg::ST_LEAD: take = tick;
      spi_stat_pkg::ST_SHIFT: take = word_end && cfg.inter_word_delay == 8'h00 && go_on;
      default: take = tick && go_on;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= spi_stat_pkg::ST_IDLE;
      cnt_ff <= 14'h0000;
      edge_ff <= 5'h00;
      sh_ff <= 16'h0000;
      rsh_ff <= 16'h0000;
      mosi_ff <= 1'b0;
      sclk_ff <= 1'b0;
      cur_ff <= 2'b00;
      cs_on_ff <= 1'b0;
      cs_lines_ff <= `CS_IDLE;
      last_ff <= 1'b0;
    end else if (take) begin
      // Load a word; a phase that samples on the leading edge puts out the first bit now
      st_ff <= spi_stat_pkg::ST_SHIFT;
      // Lead has spent its count, so the first edge follows; a one-cycle lead takes two
      if (st_ff == spi_stat_pkg::ST_LEAD) begin
        cnt_ff <= 14'h0001;
      end else begin
        cnt_ff <= half_len(ncfg.baud_divisor, 1'b0);
      end
      // A back-to-back word still owes the closing edge of the word before
      if (st_ff == spi_stat_pkg::ST_SHIFT) begin
        sclk_ff <= !sclk_ff;
      end
      edge_ff <= 5'h00;
      rsh_ff <= 16'h0000;
      last_ff <= hold_last_ff;
      if (ncfg.clock_sample_edge) begin
        mosi_ff <= aligned[15];
        sh_ff <= aligned << 1;
      end else begin
        sh_ff <= aligned;
      end
    end else begin
      case (st_ff)
        spi_stat_pkg::ST_IDLE: begin
          if (!cs_on_ff) begin
            sclk_ff <= ncfg.clock_idle_level;
          end
          if (hold_full_ff && en_ff) begin
            if (cs_on_ff) begin
              // Held select belongs to another device: drop it first
              cs_on_ff <= 1'b0;
              cs_lines_ff <= `CS_IDLE;
            end else begin
              cur_ff <= hold_cs_ff;
              cs_on_ff <= 1'b1;
              cs_lines_ff <= ~(4'h1 << hold_cs_ff);
              sclk_ff <= ncfg.clock_idle_level;
              st_ff <= spi_stat_pkg::ST_LEAD;
              if (ncfg.select_to_clock_delay == 8'h00) begin
                cnt_ff <= half_len(ncfg.baud_divisor, 1'b0) - 14'h0001;
              end else begin
                cnt_ff <= {6'h00, ncfg.select_to_clock_delay} - 14'h0001;
              end
            end
          end
        end
        spi_stat_pkg::ST_LEAD: cnt_ff <= cnt_ff - 14'h0001;
        spi_stat_pkg::ST_SHIFT: begin
          if (!tick) begin
            cnt_ff <= cnt_ff - 14'h0001;
          end else begin
            sclk_ff <= !sclk_ff;
            edge_ff <= edge_ff + 5'h01;
            cnt_ff <= half_len(cfg.baud_divisor, !edge_ff[0]);
            if (edge_ff[0] == cfg.clock_sample_edge) begin
              mosi_ff <= sh_ff[15];
              sh_ff <= sh_ff << 1;
            end else begin
              rsh_ff <= rx_next;
            end
            if (word_end) begin
              if (cfg.inter_word_delay != 8'h00) begin
                st_ff <= spi_stat_pkg::ST_GAP;
                cnt_ff <= 14'(`GAP_MULT * {6'h00, cfg.inter_word_delay});
              end else begin
                st_ff <= spi_stat_pkg::ST_IDLE;
                if (release_cs) begin
                  cs_on_ff <= 1'b0;
                  cs_lines_ff <= `CS_IDLE;
                end
              end
            end
          end
        end
        default: begin
          cnt_ff <= cnt_ff - 14'h0001;
          if (tick) begin
            // With a nonzero inter_word_delay the gap precedes any release of the select
            st_ff <= spi_stat_pkg::ST_IDLE;
            if (release_cs) begin
              cs_on_ff <= 1'b0;
              cs_lines_ff <= `CS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Receive word and its overrun check
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdr_ff <= 16'h0000;
      rx_word_ready_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      if (word_end) begin
        rdr_ff <= cfg.clock_sample_edge ? rsh_ff : rx_next;
        rx_word_ready_ff <= 1'b1;
      end else if (rd_rxd) begin
        rx_word_ready_ff <= 1'b0;
      end
      if (word_end && rx_word_ready_ff && !rd_rxd) begin
        ovr_ff <= 1'b1;
      end else if (rd_stat) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  // Events that land on the status read stay set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_fault_flag_ff <= 1'b0;
      slave_select_rise_flag_ff <= 1'b0;
      ss_prev_ff <= 1'b1;
    end else begin
      ss_prev_ff <= slave_select_input;
      if (mode_fault_event) begin
        mode_fault_flag_ff <= 1'b1;
      end else if (rd_stat) begin
        mode_fault_flag_ff <= 1'b0;
      end
      if (slave_select_input && !ss_prev_ff) begin
        slave_select_rise_flag_ff <= 1'b1;
      end else if (rd_stat) begin
        slave_select_rise_flag_ff <= 1'b0;
      end
    end
  end

  // Counters live in the DMA unit; only their zero state is seen here
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_dma_buffer_empty_ff <= 1'b0;
      rx_dma_buffer_full_ff <= 1'b0;
    end else begin
      tx_dma_buffer_empty_ff <= dma_counts.tx_cur[CNT_W-1:0] == '0
                   && dma_counts.tx_next[CNT_W-1:0] == '0;
      rx_dma_buffer_full_ff <= dma_counts.rx_cur[CNT_W-1:0] == '0
                   && dma_counts.rx_next[CNT_W-1:0] == '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txe_ff <= 1'b0;
    end else if (wr_txd) begin
      txe_ff <= 1'b0;
    end else if (st_ff == spi_stat_pkg::ST_IDLE && !hold_full_ff && !take) begin
      txe_ff <= 1'b1;
    end else if (st_ff != spi_stat_pkg::ST_IDLE) begin
      txe_ff <= 1'b0;
    end
  end

  always_comb begin
    status10 = {txe_ff, slave_select_rise_flag_ff, tx_dma_buffer_empty_ff, rx_dma_buffer_full_ff, tx_dma_count_done,
                rx_dma_count_done, ovr_ff, mode_fault_flag_ff, en_ff && !hold_full_ff, rx_word_ready_ff};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status10 & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign serial_clock_pin = sclk_ff;
  assign mosi = mosi_ff;
  assign peripheral_select_lines = cs_lines_ff;
  assign irq = irq_ff;

endmodule

// ==== spi_stat_regs.svh ====
// Register offsets, field positions and reset values of the status and chip-select block.
// Assumes byte addresses on a 32-bit APB with word-aligned registers.
`ifndef SPI_STAT_REGS_SVH
`define SPI_STAT_REGS_SVH

`define OFS_CTRL 8'h00
`define OFS_RXDATA 8'h08
`define OFS_TXDATA 8'h0c
`define OFS_STATUS 8'h10
`define OFS_IRQ_SET 8'h14
`define OFS_IRQ_CLR 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_CSCFG0 8'h30
`define OFS_CSCFG3 8'h3c

`define CTRL_EN_BIT 0
`define CTRL_DIS_BIT 1
`define TXD_CS_LSB 16
`define TXD_LAST_BIT 24
`define STAT_ENS_BIT 16
`define SRC_CNT 10

`define CSCFG_RST 32'h0000_0000
`define MASK_RST 10'h000
`define CSCFG_RSV_MASK 32'hffff_fffb
`define GAP_MULT 14'h0020
`define WLEN_BASE 5'h08
`define WLEN_MAX_CODE 4'h8
`define CS_IDLE 4'hf

`endif

// ==== spi_stat_pkg.sv ====
// Types shared by the status and chip-select block.
// Field layout of the configuration word follows the register bit order.
package spi_stat_pkg;

  typedef struct packed {
    logic [7:0] inter_word_delay;
    logic [7:0] select_to_clock_delay;
    logic [7:0] baud_divisor;
    logic [3:0] word_bits;
    logic chip_select_hold;
    logic reserved;
    logic clock_sample_edge;
    logic clock_idle_level;
  } cs_cfg_t;

  typedef struct packed {
    logic [15:0] rx_cur;
    logic [15:0] rx_next;
    logic [15:0] tx_cur;
    logic [15:0] tx_next;
  } dma_counts_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_GAP = 2'b10
  } eng_state_t;

endpackage

// ==== spi_stat_cs_sva.sv ====
// Port-level checks of the status and chip-select block.
// Assumes one clock and the register map of spi_stat_regs.svh.
`timescale 1ns/1ps
`include "spi_stat_regs.svh"
module spi_stat_cs_sva #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire spi_stat_pkg::dma_counts_t dma_counts,
  input wire logic serial_clock_pin,
  input wire logic [3:0] peripheral_select_lines,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [9:0] mask_ff;
  logic en_ff;
  logic wr_done;
  logic rd_done;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_ff <= `MASK_RST;
    end else if (wr_done && paddr == `OFS_IRQ_SET) begin
      mask_ff <= mask_ff | pwdata[9:0];
    end else if (wr_done && paddr == `OFS_IRQ_CLR) begin
      mask_ff <= mask_ff & ~pwdata[9:0];
    end
  end
  // Disable wins when both control bits are written
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_ff <= 1'b0;
    end else if (wr_done && paddr == `OFS_CTRL && pwdata[1:0] != 2'h0) begin
      en_ff <= !pwdata[1];
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  AST_ONE_WAIT: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("answer not in second access cycle");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  AST_MASK_VIEW: assert property (
    rd_done && paddr == `OFS_IRQ_MASK |-> prdata[9:0] == mask_ff)
    else $error("mask view differs from set and clear history");
  AST_ENABLE_BIT: assert property (
    rd_done && paddr == `OFS_STATUS && peripheral_select_lines == `CS_IDLE
      |-> prdata[`STAT_ENS_BIT] == en_ff)
    else $error("enable status wrong");
  AST_TX_BUF_EMPTY: assert property (
    rd_done && paddr == `OFS_STATUS && $past(dma_counts) == dma_counts
      && $past(dma_counts, 3) == dma_counts
      |-> prdata[7] == (dma_counts.tx_cur[CNT_W-1:0] == '0
        && dma_counts.tx_next[CNT_W-1:0] == '0))
    else $error("buffer empty flag wrong");
  AST_IRQ_OFF: assert property (
    wr_done && paddr == `OFS_IRQ_CLR && pwdata[9:0] == 10'h3ff |-> ##2 !irq)
    else $error("interrupt stays with all sources disabled");
  AST_SEL_HOP: assert property (
    peripheral_select_lines != `CS_IDLE && $past(peripheral_select_lines) != `CS_IDLE
      |-> $stable(peripheral_select_lines))
    else $error("select moved without idle cycle");
  AST_CLK_QUIET: assert property (
    peripheral_select_lines == `CS_IDLE && $past(peripheral_select_lines) == `CS_IDLE
      && !$past(wr_done, 2) |-> $stable(serial_clock_pin))
    else $error("serial clock moved while deselected");
endmodule
bind spi_stat_cs spi_stat_cs_sva #(.CNT_W(CNT_W)) u_sva (.core_clk(core_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_counts(dma_counts),
  .serial_clock_pin(serial_clock_pin), .peripheral_select_lines(peripheral_select_lines),
  .irq(irq));

// ==== spi_peer.sv ====
// Serial peripheral model on the far side of select, clock and data lines.
// Assumes the bench tells it the mode and word length it programmed.
`timescale 1ns/1ps
module spi_peer (
  input wire logic core_clk,
  input wire logic [3:0] sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic idle_lvl,
  input wire logic cap_lead,
  input wire logic [4:0] bits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  logic [15:0] sh;
  logic [3:0] sel_q;
  initial miso = 1'b0;
  initial sel_q = 4'hf;
  // A released line keeps no stale bit, so it toggles every cycle
  always @(posedge core_clk) begin
    sel_q <= sel_n;
    if (sel_n == 4'hf) begin
      miso <= ~miso;
    end
  end
  always @(negedge (&sel_n)) begin
    sh = reply << (16 - bits);
    if (cap_lead) begin
      miso <= sh[15];
      sh = sh << 1;
    end
  end
  // Select seen at the last clock edge: idle-level switches at selection and the
  // final edge at release fall on the right side without racing the select lines
  always @(sck) begin
    if (sel_q != 4'hf) begin
      if ((sck != idle_lvl) == cap_lead) begin
        got <= {got[14:0], mosi};
      end else begin
        miso <= sh[15];
        sh = sh << 1;
      end
    end
  end
endmodule

// ==== spi_stat_cs_tb_top.sv ====
// Bench of the status and chip-select block with APB traffic and a serial peer.
// Assumes the register map of spi_stat_regs.svh; results are checked through queues.
`timescale 1ns/1ps
`include "spi_stat_regs.svh"
module spi_stat_cs_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rxd = 1'b0, txd = 1'b0, mfe = 1'b0, ssi = 1'b0, idle_lvl = 1'b0, cap_lead = 1'b0;
  logic pready, pslverr, miso, sck, mosi, irq, err_q;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h73bb;
  logic [3:0] sel_n, sel_q = 4'hf;
  logic [4:0] bits = 5'h08;
  logic [15:0] reply = 16'h0, got;
  logic [63:0] aq[$], sq[$];
  spi_stat_pkg::dma_counts_t dma_counts = '0;
  int n_fail = 0, comparisons = 0;
  spi_stat_cs dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_counts(dma_counts), .rx_dma_count_done(rxd),
    .tx_dma_count_done(txd), .mode_fault_event(mfe), .slave_select_input(ssi),
    .miso(miso), .serial_clock_pin(sck), .mosi(mosi), .peripheral_select_lines(sel_n),
    .irq(irq));
  spi_peer peer (.core_clk(core_clk), .sel_n(sel_n), .sck(sck), .mosi(mosi),
    .idle_lvl(idle_lvl), .cap_lead(cap_lead), .bits(bits), .reply(reply), .miso(miso),
    .got(got));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reads note their masked expectation before the request goes out
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] e);
    if (!w) begin
      aq.push_back({m, e & m});
    end
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic hold_while(input logic [3:0] v, input logic eq);
    int k;
    k = 0;
    while ((sel_n === v) == eq && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    check(32'(k < 3000), 32'h1);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      bus(`OFS_STATUS, 1'b0, 32'h0, 32'h0, 32'h0);
      k++;
    end while (q[9] !== 1'b1 && k < 200);
    check(32'(q[9]), 32'h1);
  endtask
  always @(posedge core_clk) begin
    logic [63:0] t;
    sel_q <= sel_n;
    if (psel && penable && pready && !pwrite && aq.size() > 0) begin
      t = aq.pop_front();
      check(prdata & t[63:32], t[31:0]);
    end
    if (sel_q != 4'hf && sel_n == 4'hf && sq.size() > 0) begin
      t = sq.pop_front();
      check(32'(got) & t[63:32], t[31:0]);
    end
  end
  initial begin
    #1000000;
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] r, c, d, m;
    spi_stat_pkg::cs_cfg_t cfg;
    int k;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(`OFS_IRQ_MASK, 1'b0, 32'h0, 32'h3ff, 32'(`MASK_RST));
    bus(`OFS_CSCFG3, 1'b0, 32'h0, 32'hffffffff, `CSCFG_RST);
    r = rnd();
    c = rnd();
    bus(`OFS_IRQ_SET, 1'b1, r, 32'h0, 32'h0);
    bus(`OFS_IRQ_SET, 1'b1, 32'h0, 32'h0, 32'h0);
    bus(`OFS_IRQ_MASK, 1'b1, 32'hffffffff, 32'h0, 32'h0);
    bus(`OFS_IRQ_CLR, 1'b1, c, 32'h0, 32'h0);
    bus(`OFS_IRQ_MASK, 1'b0, 32'h0, 32'h3ff, r & ~c);
    bus(8'h04, 1'b0, 32'h0, 32'hffffffff, 32'h0);
    check(32'(err_q), 32'h1);
    $display("test registers done");
    bus(`OFS_IRQ_CLR, 1'b1, 32'h3ff, 32'h0, 32'h0);
    bus(`OFS_IRQ_SET, 1'b1, 32'h80, 32'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      dma_counts <= {16'(rnd()), 16'(rnd()), (i == 1) ? 16'(rnd() | 32'h1) : 16'h0,
        (i == 2) ? 16'h1 : 16'h0};
      rxd <= i[0];
      txd <= i[1];
      repeat (4) @(posedge core_clk);
      check(32'(irq), 32'(i == 0));
      bus(`OFS_STATUS, 1'b0, 32'h0, 32'hb0, {24'h0, i == 0, 1'b0, i[1:0], 4'h0});
    end
    bus(`OFS_IRQ_CLR, 1'b1, 32'h3ff, 32'h0, 32'h0);
    $display("test buffer flag and interrupt done");
    ssi <= 1'b1;
    mfe <= 1'b1;
    @(posedge core_clk);
    mfe <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(`OFS_STATUS, 1'b0, 32'h0, 32'h104, 32'h104);
    bus(`OFS_STATUS, 1'b0, 32'h0, 32'h104, 32'h0);
    bus(`OFS_CTRL, 1'b1, 32'h1, 32'h0, 32'h0);
    bus(`OFS_STATUS, 1'b0, 32'h0, 32'h10000, 32'h10000);
    $display("test event flags done");
    for (int i = 0; i < 4; i++) begin
      cfg = '0;
      cfg.clock_idle_level = i[0];
      cfg.clock_sample_edge = i[1];
      cfg.word_bits = (i == 1) ? `WLEN_MAX_CODE : 4'(i);
      cfg.baud_divisor = 8'(i + 1);
      cfg.select_to_clock_delay = (i == 2) ? 8'h00 : 8'(i + 2);
      cfg.inter_word_delay = 8'(i[0]);
      idle_lvl <= i[0];
      cap_lead <= i[1];
      bits <= 5'(cfg.word_bits) + 5'h08;
      reply <= 16'(rnd());
      d = rnd();
      m = (32'h1 << (cfg.word_bits + 5'h08)) - 32'h1;
      bus(`OFS_CSCFG0 + 8'(4 * i), 1'b1, cfg, 32'h0, 32'h0);
      bus(`OFS_CSCFG0 + 8'(4 * i), 1'b0, 32'h0, 32'hffffffff, cfg);
      sq.push_back({m, d & m});
      bus(`OFS_TXDATA, 1'b1, {7'h0, 1'b1, 6'h0, 2'(i), d[15:0]}, 32'h0, 32'h0);
      hold_while(4'hf, 1'b1);
      k = 0;
      while (sck === cfg.clock_idle_level && k < 600) begin
        @(posedge core_clk);
        k++;
      end
      check(32'(k), (i == 2) ? 32'h2 : 32'(i + 2));
      bus(`OFS_STATUS, 1'b0, 32'h0, 32'h200, 32'h0);
      hold_while(4'hf, 1'b0);
      wait_idle();
      bus(`OFS_RXDATA, 1'b0, 32'h0, m, 32'(reply));
      check(32'(sck), 32'(i[0]));
    end
    $display("test word formats done");
    cfg = '0;
    cfg.chip_select_hold = 1'b1;
    cfg.baud_divisor = 8'h02;
    idle_lvl <= 1'b0;
    cap_lead <= 1'b0;
    bits <= 5'h08;
    bus(`OFS_CSCFG0, 1'b1, cfg, 32'h0, 32'h0);
    bus(`OFS_CSCFG0 + 8'h04, 1'b1, cfg, 32'h0, 32'h0);
    bus(`OFS_TXDATA, 1'b1, rnd() & 32'hffff, 32'h0, 32'h0);
    hold_while(4'hf, 1'b1);
    wait_idle();
    check(32'(sel_n), 32'he);
    d = rnd();
    bus(`OFS_TXDATA, 1'b1, {7'h0, 1'b1, 6'h0, 2'h1, d[15:0]}, 32'h0, 32'h0);
    hold_while(4'he, 1'b1);
    check(32'(sel_n), 32'hf);
    hold_while(4'hf, 1'b1);
    check(32'(sel_n), 32'hd);
    // Noted only once the dropped select is past, so that release pops nothing
    sq.push_back({32'hff, 32'(d[7:0])});
    hold_while(4'hf, 1'b0);
    bus(`OFS_CTRL, 1'b1, 32'h3, 32'h0, 32'h0);
    // Second word landed on an unread receive word
    bus(`OFS_STATUS, 1'b0, 32'h0, 32'h10008, 32'h8);
    $display("test select hold done");
    test_done();
  end
endmodule
